// file: hw/gdpc_lut_ram.sv
/*
 Colour table storage: one write port, one registered read port.
 Assumes the caller arbitrates the single read address.
*/
`timescale 1ns/1ps
module gdpc_lut_ram #(
	parameter int AW = 8,
	parameter int DW = 16
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [2**AW];

	// No reset on the array, so it maps onto block memory
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// file: hw/gdpc_pkg.sv
/*
 Shared constants and types for the display port control block.
 Assumes one 250 MHz clock, AHB-Lite word access and 16-bit registers.
*/
// Operation
// - In TFT mode the panel enable output is active-high when its polarity bit is 1, else low.
// - In either STN mode with polarity 1 the panel enable output carries the shift clock.
// - The rect copy done event raises the interrupt only while its enable bit is 1.
// - The command watermark event raises the interrupt only while its enable bit is 1.
// - Pixels go through the colour table only while the table is on, else pass unchanged.
// - The busy flag is 1 while a software table access runs and clears when it ends.
// - A read trigger under software access loads the indexed entry into read data.
// - While software access is 1 the display path is kept off the table.
// - An eight-bit index selects one of 256 entries for software access.
package gdpc_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0]  OFS_DCTL    = 8'h00;
	localparam logic [7:0]  OFS_IRQEN   = 8'h04;
	localparam logic [7:0]  OFS_LUTCTL  = 8'h08;
	localparam logic [7:0]  OFS_LUTRD   = 8'h0C;
	localparam logic [7:0]  OFS_LUTWR   = 8'h10;
	localparam logic [7:0]  OFS_IRQSTAT = 8'h14;
	localparam logic [15:0] DCTL_MASK   = 16'h03FF;
	localparam logic [15:0] IRQ_MASK    = 16'h80FF;
	localparam logic [15:0] LUTCTL_WMSK = 16'h83FF;
	localparam logic [15:0] REG_RESET   = 16'h0000;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int DC_PIN_OE  = 9;
	localparam int DC_PWR_LVL = 8;
	localparam int DC_CLK_EDG = 7;
	localparam int DC_EN_POL  = 6;
	localparam int DC_VS_POL  = 5;
	localparam int DC_HS_POL  = 4;
	localparam int DC_PWR_OE  = 3;
	localparam int DC_EN_OE   = 2;
	localparam int DC_VS_OE   = 1;
	localparam int DC_HS_OE   = 0;
	localparam int LC_ON      = 15;
	localparam int LC_BUSY    = 14;
	localparam int LC_TRIG    = 9;
	localparam int LC_SW      = 8;
	localparam int IE_RCC     = 6;
	localparam int IE_VBLANK  = 4;
	localparam int IE_WMARK   = 2;
	// ----------------------------------------
	// Modes and bus codes
	// ----------------------------------------
	localparam logic [2:0]  MODE_TFT    = 3'h1;
	localparam logic [2:0]  MODE_STN_A  = 3'h2;
	localparam logic [2:0]  MODE_STN_B  = 3'h3;
	localparam logic [2:0]  HSIZE_WORD  = 3'h2;
	localparam int          LUT_AW      = 8;
	localparam int          LUT_DW      = 16;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {LS_IDLE, LS_RD, LS_CAP, LS_WR} gdpc_lut_st_t;
	typedef struct packed {
		logic enable;
		logic hsync;
		logic vsync;
		logic shift_clk;
		logic glass_clk;
	} gdpc_tmg_t;
	typedef struct packed {
		logic panel_enable_out;
		logic panel_enable_oe;
		logic hsync_out;
		logic hsync_oe;
		logic vsync_out;
		logic vsync_oe;
		logic glass_clock_out;
		logic panel_power_out;
		logic panel_power_oe;
	} gdpc_pads_t;
endpackage

// file: hw/gdpc_top.sv
/*
 Display port control: pad polarity, interrupt gating, colour table access.
 Assumes an AHB-Lite master, timing signals synchronous to hclk.
*/
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module gdpc_top
	import gdpc_pkg::*;
#(
	parameter int AW = LUT_AW,
	parameter int DW = LUT_DW
) (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic               hresp,
	output logic      [31:0]   hrdata,
	input  wire logic [2:0]    panel_type_sel,
	input  wire gdpc_tmg_t     tmg,
	input  wire logic [15:0]   gfx_events,
	input  wire logic          pix_valid,
	input  wire logic [AW-1:0] pix_index,
	output logic               pix_out_valid,
	output logic      [DW-1:0] pix_out,
	output gdpc_pads_t         pads,
	output logic               irq
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic         ap_valid;
		logic         ap_write;
		logic         ap_word;
		logic [7:0]   ap_addr;
		logic         rd_pend;
		logic         hready;
		logic [31:0]  hrdata;
		logic [15:0]  dctl;
		logic [15:0]  irqen;
		logic [15:0]  status;
		logic [15:0]  lutctl;
		logic [DW-1:0] lutrd;
		logic [DW-1:0] lutwr;
		gdpc_lut_st_t lst;
		logic         trig_prev;
		logic         p1_valid;
		logic         p1_map;
		logic [AW-1:0] p1_raw;
		logic         pix_vld;
		logic [DW-1:0] pix;
		gdpc_pads_t   pads;
		logic         irq;
	} gdpc_state_t;

	gdpc_state_t   s_q;
	gdpc_state_t   s_d;
	logic [DW-1:0] ram_rdata;
	logic [AW-1:0] ram_raddr;
	logic          ram_we;
	logic          trig_lvl;
	logic          stn_mode;
	logic          accept;

	function automatic logic [15:0] reg_read(input gdpc_state_t s, input logic [7:0] a);
		logic [15:0] v;
		v = 16'h0000;
		unique case (a)
			OFS_DCTL:    v = s.dctl;
			OFS_IRQEN:   v = s.irqen;
			OFS_LUTCTL:  v = s.lutctl | {1'b0, (s.lst != LS_IDLE), 14'h0000};
			OFS_LUTRD:   v = 16'(s.lutrd);
			OFS_LUTWR:   v = 16'(s.lutwr);
			OFS_IRQSTAT: v = s.status;
			default:     v = 16'h0000;
		endcase
		return v;
	endfunction

	function automatic logic polar(input logic pol, input logic lvl);
		return pol ? lvl : ~lvl;
	endfunction

	// ----------------------------------------
	// Table storage
	// ----------------------------------------
	// One read port: software owns it while access is on
	assign ram_raddr = s_q.lutctl[LC_SW] ? s_q.lutctl[AW-1:0] : pix_index;
	assign ram_we    = (s_q.lst == LS_WR);
	assign trig_lvl  = s_q.lutctl[LC_TRIG] & s_q.lutctl[LC_SW];
	assign stn_mode  = (panel_type_sel == MODE_STN_A) || (panel_type_sel == MODE_STN_B);
	assign accept    = hsel & hready & htrans[1];

	gdpc_lut_ram #(
		.AW (AW),
		.DW (DW)
	) u_lut (
		.clk   (hclk),
		.we    (ram_we),
		.waddr (s_q.lutctl[AW-1:0]),
		.wdata (s_q.lutwr),
		.raddr (ram_raddr),
		.rdata (ram_rdata)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [15:0] wd;
		logic        wr_ok;
		s_d = s_q;
		wd = hwdata[15:0];
		wr_ok = s_q.ap_valid & s_q.ap_write & s_q.ap_word;

		// Bus address phase
		s_d.ap_valid = accept;
		if (accept) begin
			s_d.ap_write = hwrite;
			s_d.ap_word = (hsize == HSIZE_WORD);
			s_d.ap_addr = haddr[7:0];
		end
		// Reads take one wait state so a write just before is seen
		if (accept && !hwrite) begin
			s_d.rd_pend = 1'b1;
			s_d.hready = 1'b0;
		end
		if (s_q.rd_pend) begin
			s_d.rd_pend = 1'b0;
			s_d.hready = 1'b1;
			s_d.hrdata = {16'h0000, reg_read(s_q, s_q.ap_addr)};
		end

		// Register writes, sub-word writes ignored
		if (wr_ok) begin
			unique case (s_q.ap_addr)
				OFS_DCTL:   s_d.dctl = wd & DCTL_MASK;
				OFS_IRQEN:  s_d.irqen = wd & IRQ_MASK;
				OFS_LUTCTL: s_d.lutctl = wd & LUTCTL_WMSK & ~(16'h0001 << LC_BUSY);
				OFS_LUTWR: begin
					s_d.lutwr = wd[DW-1:0];
					if (s_q.lutctl[LC_SW] && s_q.lst == LS_IDLE) begin
						s_d.lst = LS_WR;
					end
				end
				default: ;
			endcase
		end

		// Sticky events, set wins over a same-cycle clear
		s_d.status = s_q.status;
		if (wr_ok && s_q.ap_addr == OFS_IRQSTAT) begin
			s_d.status = s_q.status & ~wd;
		end
		s_d.status = s_d.status | (gfx_events & IRQ_MASK);
		s_d.irq = |(s_q.status & s_q.irqen);

		// Software table access
		// Edge held while busy, so a trigger set during an entry write still fires
		if (s_q.lst == LS_IDLE) begin
			s_d.trig_prev = trig_lvl;
		end
		unique case (s_q.lst)
			LS_IDLE: begin
				if (trig_lvl && !s_q.trig_prev) begin
					s_d.lst = LS_RD;
				end
			end
			LS_RD:   s_d.lst = LS_CAP;
			LS_CAP: begin
				s_d.lutrd = ram_rdata;
				s_d.lst = LS_IDLE;
			end
			LS_WR:   s_d.lst = LS_IDLE;
		endcase

		// Pixel path, two cycles
		s_d.p1_valid = pix_valid;
		s_d.p1_raw = pix_index;
		s_d.p1_map = s_q.lutctl[LC_ON] & ~s_q.lutctl[LC_SW];
		s_d.pix_vld = s_q.p1_valid;
		s_d.pix = s_q.p1_map ? ram_rdata : DW'(s_q.p1_raw);

		// Pads
		if (stn_mode && s_q.dctl[DC_EN_POL]) begin
			s_d.pads.panel_enable_out = tmg.shift_clk;
		end else begin
			s_d.pads.panel_enable_out = polar(s_q.dctl[DC_EN_POL], tmg.enable);
		end
		s_d.pads.hsync_out = polar(s_q.dctl[DC_HS_POL], tmg.hsync);
		s_d.pads.vsync_out = polar(s_q.dctl[DC_VS_POL], tmg.vsync);
		s_d.pads.glass_clock_out = polar(s_q.dctl[DC_CLK_EDG], tmg.glass_clk);
		s_d.pads.panel_power_out = s_q.dctl[DC_PWR_LVL];
		// Master enable gates every pad enable
		s_d.pads.panel_enable_oe = s_q.dctl[DC_PIN_OE] & s_q.dctl[DC_EN_OE];
		s_d.pads.hsync_oe = s_q.dctl[DC_PIN_OE] & s_q.dctl[DC_HS_OE];
		s_d.pads.vsync_oe = s_q.dctl[DC_PIN_OE] & s_q.dctl[DC_VS_OE];
		s_d.pads.panel_power_oe = s_q.dctl[DC_PIN_OE] & s_q.dctl[DC_PWR_OE];
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0;
			s_q.hready <= 1'b1;
			s_q.lst <= LS_IDLE;
			s_q.dctl <= REG_RESET;
			s_q.irqen <= REG_RESET;
			s_q.lutctl <= REG_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign hreadyout     = s_q.hready;
	assign hresp         = 1'b0;
	assign hrdata        = s_q.hrdata;
	assign pix_out_valid = s_q.pix_vld;
	assign pix_out       = s_q.pix;
	assign pads          = s_q.pads;
	assign irq           = s_q.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Readback lands one edge after the wait state, so bus checks look one edge on

	tft_enable_pol_a: assert property (
		(panel_type_sel == MODE_TFT && !s_q.dctl[DC_EN_POL])
		|=> pads.panel_enable_out == !$past(tmg.enable))
		else $error("tft enable polarity wrong");

	stn_shift_clk_a: assert property (
		(stn_mode && s_q.dctl[DC_EN_POL])
		|=> pads.panel_enable_out == $past(tmg.shift_clk))
		else $error("stn shift clock not routed");

	rect_irq_gate_a: assert property (
		(s_q.status[IE_RCC] && !s_q.irqen[IE_RCC] && (s_q.status & s_q.irqen) == 16'h0000)
		|=> !irq)
		else $error("masked rect copy raised irq");

	vblank_irq_a: assert property (
		(gfx_events[IE_VBLANK] && s_q.irqen[IE_VBLANK] && s_d.irqen[IE_VBLANK])
		|-> ##2 irq)
		else $error("vblank irq missing");

	wmark_irq_a: assert property (
		(s_q.status[IE_WMARK] && s_q.irqen[IE_WMARK]) |=> irq)
		else $error("watermark irq missing");

	lut_bypass_a: assert property (
		(s_q.p1_valid && !s_q.p1_map) |=> pix_out == DW'($past(s_q.p1_raw)) && pix_out_valid)
		else $error("bypass pixel altered");

	read_busy_seq_a: assert property (
		(s_q.lst == LS_IDLE && trig_lvl && !s_q.trig_prev)
		|=> (s_q.lst != LS_IDLE) [*2] ##1 (s_q.lst == LS_IDLE))
		else $error("busy window wrong");

	read_capture_a: assert property (
		(s_q.lst == LS_CAP) |=> s_q.lutrd == $past(ram_rdata))
		else $error("read data not captured");

	sw_index_a: assert property (
		(s_q.lst == LS_RD || s_q.lst == LS_WR) |-> ram_raddr == s_q.lutctl[AW-1:0])
		else $error("software index not used");

	display_barred_a: assert property (
		s_q.lutctl[LC_SW] |=> !s_q.p1_map)
		else $error("display reached table");

	sync_pol_a: assert property (
		s_q.dctl[DC_VS_POL] && !s_q.dctl[DC_HS_POL]
		|=> pads.vsync_out == $past(tmg.vsync) && pads.hsync_out == !$past(tmg.hsync))
		else $error("sync polarity wrong");

	reserved_zero_a: assert property (
		(s_q.dctl & ~DCTL_MASK) == 16'h0000 && (s_q.irqen & ~IRQ_MASK) == 16'h0000
		&& (s_q.lutctl & ~LUTCTL_WMSK) == 16'h0000)
		else $error("reserved bit set");

	tft_enable_high_a: assert property (
		(panel_type_sel == MODE_TFT && s_q.dctl[DC_EN_POL])
		|=> pads.panel_enable_out == $past(tmg.enable))
		else $error("tft enable not active high");

	stn_low_pol_a: assert property (
		(stn_mode && !s_q.dctl[DC_EN_POL])
		|=> pads.panel_enable_out == !$past(tmg.enable))
		else $error("stn enable level wrong");

	rect_irq_fwd_a: assert property (
		(s_q.status[IE_RCC] && s_q.irqen[IE_RCC]) |=> irq)
		else $error("enabled rect copy lost");

	irq_masked_a: assert property (
		((s_q.status & s_q.irqen) == 16'h0000) |=> !irq)
		else $error("irq without enabled event");

	wmark_sticky_a: assert property (
		gfx_events[IE_WMARK] |=> s_q.status[IE_WMARK])
		else $error("watermark event not latched");

	lut_mapped_a: assert property (
		(s_q.p1_valid && s_q.p1_map) |=> pix_out == $past(ram_rdata) && pix_out_valid)
		else $error("mapped pixel wrong");

	write_busy_a: assert property (
		(s_q.ap_valid && s_q.ap_write && s_q.ap_word && s_q.ap_addr == OFS_LUTWR
		&& s_q.lutctl[LC_SW] && s_q.lst == LS_IDLE && !(trig_lvl && !s_q.trig_prev))
		|=> (s_q.lst == LS_WR) ##1 (s_q.lst == LS_IDLE))
		else $error("write busy window wrong");

	busy_readback_a: assert property (
		(s_q.rd_pend && s_q.ap_addr == OFS_LUTCTL)
		|=> hrdata[LC_BUSY] == ($past(s_q.lst) != LS_IDLE))
		else $error("busy flag misread");

	sync_pol_inv_a: assert property (
		!s_q.dctl[DC_VS_POL] && s_q.dctl[DC_HS_POL]
		|=> pads.vsync_out == !$past(tmg.vsync) && pads.hsync_out == $past(tmg.hsync))
		else $error("sync polarity inverted");

	lutctl_unused_a: assert property (
		(s_q.rd_pend && s_q.ap_addr == OFS_LUTCTL)
		|=> hrdata[13:10] == 4'h0 && hrdata[31:16] == 16'h0000)
		else $error("unused table bits read");

	status_reserved_a: assert property (
		(s_q.status & ~IRQ_MASK) == 16'h0000)
		else $error("reserved status bit set");
endmodule

// file: test/gdpc_panel_model.sv
/*
 Panel-side partner: produces the raw timing levels that feed the pads.
 Assumes the block samples these levels on the rising edge of hclk.
*/
`timescale 1ns/1ps
module gdpc_panel_model
	import gdpc_pkg::*;
(
	input  wire logic hclk,
	input  wire logic hresetn,
	output gdpc_tmg_t tmg
);
	logic [31:0] cnt_q;
	// ----
	// Timing source
	// ----
	// Irregular pattern, so every level is seen in both states
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 32'h0000CE97;
			tmg <= '0;
		end else begin
			cnt_q <= {cnt_q[30:0], cnt_q[31] ^ cnt_q[21] ^ cnt_q[1] ^ cnt_q[0]};
			// Shift clock stands still outside the active line
			tmg <= {cnt_q[4:2], cnt_q[4] & cnt_q[1], cnt_q[0]};
		end
	end
endmodule

// file: test/gdpc_top_test.sv
/*
 Self-checking bench of the display port control block.
 Assumes one AHB-Lite slave whose hreadyout loops back as hready.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module gdpc_top_test;
	import gdpc_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        pix_valid = 1'b0, pad_chk = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, seed = 32'h0000CE97, d, r;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h0, panel_type_sel = 3'h0;
	logic [15:0] gfx_events = 16'h0, pix_out, c, v, dctl;
	logic [7:0]  pix_index = 8'h0, a;
	logic [7:0]  used [4];
	logic [15:0] lut_m [256];
	logic [7:0]  ofs [4] = '{OFS_DCTL, OFS_IRQEN, OFS_LUTCTL, 8'h18};
	logic [15:0] wmask [4] = '{DCTL_MASK, IRQ_MASK, 16'h81FF, 16'h0000};
	logic [15:0] cfg [3] = '{16'h8000, 16'h8100, 16'h0000};
	logic        hreadyout, hresp, pix_out_valid, irq;
	gdpc_tmg_t   tmg, tprev;
	gdpc_pads_t  pads;
	int          err_count = 0, n_checks = 0, b;
	logic [31:0] hrdata;

	gdpc_top u_gdpc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .panel_type_sel(panel_type_sel),
		.tmg(tmg), .gfx_events(gfx_events), .pix_valid(pix_valid), .pix_index(pix_index),
		.pix_out_valid(pix_out_valid), .pix_out(pix_out), .pads(pads), .irq(irq));
	gdpc_panel_model u_gdpc_panel_model (.hclk(hclk), .hresetn(hresetn), .tmg(tmg));

	// ----
	// Helpers
	// ----
	function automatic logic [31:0] nxt();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction

	function automatic gdpc_pads_t exp_pads(input logic [15:0] k, input logic [2:0] m,
		input gdpc_tmg_t t);
		gdpc_pads_t p;
		p.panel_enable_out = ((m == MODE_STN_A || m == MODE_STN_B) && k[DC_EN_POL]) ?
			t.shift_clk : t.enable ~^ k[DC_EN_POL];
		p.panel_enable_oe = k[DC_PIN_OE] & k[DC_EN_OE];
		p.hsync_out = t.hsync ~^ k[DC_HS_POL];
		p.hsync_oe = k[DC_PIN_OE] & k[DC_HS_OE];
		p.vsync_out = t.vsync ~^ k[DC_VS_POL];
		p.vsync_oe = k[DC_PIN_OE] & k[DC_VS_OE];
		p.glass_clock_out = t.glass_clk ~^ k[DC_CLK_EDG];
		p.panel_power_out = k[DC_PWR_LVL];
		p.panel_power_oe = k[DC_PIN_OE] & k[DC_PWR_OE];
		return p;
	endfunction

	// Level sampled one edge before the pad, read back where it is settled
	task automatic bus(input logic w, input logic [7:0] ad, input logic [15:0] wd);
		logic ok;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, ad};
		hwrite <= w;
		hsize <= HSIZE_WORD;
		do begin @(negedge hclk); ok = hreadyout; @(posedge hclk); end while (ok !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {16'h0, wd};
		do begin @(negedge hclk); ok = hreadyout; d = hrdata; @(posedge hclk); end
			while (ok !== 1'b1);
		`CHK("hresp", 1'b0, hresp)
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always #2 hclk = ~hclk;
	always @(posedge hclk) tprev <= tmg;
	always @(negedge hclk) if (pad_chk) begin
		`CHK("pads", exp_pads(dctl, panel_type_sel, tprev), pads)
	end

	initial begin
		repeat (20000) @(posedge hclk);
		err_count++;
		report_and_stop();
	end

	// ----
	// Scenarios
	// ----
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (ofs[i]) begin
			bus(1'b0, ofs[i], 16'h0);
			`CHK("reset", 32'h0, d)
		end
		foreach (ofs[i]) bus(1'b1, ofs[i], (i == 2) ? 16'hFDFF : 16'hFFFF);
		foreach (ofs[i]) begin
			bus(1'b0, ofs[i], 16'h0);
			`CHK("mask", {16'h0, wmask[i]}, d)
		end
		bus(1'b1, OFS_LUTCTL, 16'h0000);
		// Every mode against both polarities, master enable on and off
		for (int i = 0; i < 12; i++) begin
			r = nxt();
			c = r[15:0] & DCTL_MASK;
			c[DC_EN_POL] = i[0];
			c[DC_PIN_OE] = i[1];
			dctl = c;
			bus(1'b1, OFS_DCTL, c);
			panel_type_sel <= (i < 4) ? MODE_TFT : (i < 8) ? MODE_STN_A : MODE_STN_B;
			repeat (3) @(posedge hclk);
			pad_chk = 1'b1;
			repeat (16) @(posedge hclk);
			pad_chk = 1'b0;
		end
		for (int i = 0; i < 6; i++) begin
			b = (i < 2) ? IE_RCC : (i < 4) ? IE_VBLANK : IE_WMARK;
			bus(1'b1, OFS_IRQEN, {15'h0, i[0]} << b);
			gfx_events <= 16'h1 << b;
			@(posedge hclk);
			gfx_events <= 16'h0;
			@(posedge hclk);
			@(negedge hclk);
			`CHK("irq", i[0], irq)
			@(posedge hclk);
			bus(1'b0, OFS_IRQSTAT, 16'h0);
			`CHK("status", 32'h1 << b, d)
			bus(1'b1, OFS_IRQSTAT, 16'h1 << b);
			@(posedge hclk);
			@(negedge hclk);
			`CHK("irq clear", 1'b0, irq)
			@(posedge hclk);
		end
		// Table ends first, then random slots
		for (int i = 0; i < 4; i++) begin
			r = nxt();
			a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : r[7:0];
			v = r[31:16];
			used[i] = a;
			bus(1'b1, OFS_LUTCTL, {8'h01, a});
			bus(1'b1, OFS_LUTWR, v);
			lut_m[a] = v;
			bus(1'b1, OFS_LUTCTL, {8'h03, a});
			bus(1'b0, OFS_LUTCTL, 16'h0);
			`CHK("lut busy", {16'h0, 8'h43, a}, d)
			bus(1'b0, OFS_LUTCTL, 16'h0);
			`CHK("lut ctl", {16'h0, 8'h03, a}, d)
			bus(1'b0, OFS_LUTRD, 16'h0);
			`CHK("lut data", {16'h0, v}, d)
			bus(1'b1, OFS_LUTCTL, {8'h01, a});
		end
		foreach (cfg[k]) begin
			bus(1'b1, OFS_LUTCTL, cfg[k]);
			foreach (used[j]) begin
				pix_valid <= 1'b1;
				pix_index <= used[j];
				repeat (2) @(posedge hclk);
				@(negedge hclk);
				`CHK("pix", (k == 0) ? lut_m[used[j]] : {8'h0, used[j]}, pix_out)
				`CHK("pix valid", 1'b1, pix_out_valid)
				@(posedge hclk);
			end
		end
		pix_valid <= 1'b0;
		report_and_stop();
	end
endmodule
